// File: verilog/tfp_pkg.sv
// shared constants and carriers of the thermal fan pwm controller
// assumes one 125 MHz clock and comparator results already in logic levels
package tfp_pkg;

	localparam int unsigned CLK_HZ = 125000000;
	// time base rate, nominal figure of the band 30 to 60 Hz
	localparam int unsigned TIME_BASE_HZ = 30;
	localparam int unsigned DUTY_W = 8;
	// triangle steps per time base period: up DUTY_MAX and back down
	localparam int unsigned DUTY_MAX = 255;
	localparam int unsigned TRI_STEPS = 2 * DUTY_MAX;
	localparam int unsigned STEP_CYCLES = CLK_HZ / (TIME_BASE_HZ * TRI_STEPS);
	localparam int unsigned STARTUP_PERIODS = 64;
	localparam int unsigned STEP_W = 16;
	localparam int unsigned PER_W = 7;

	localparam logic [DUTY_W-1:0] DUTY_ZERO = 8'h00;
	localparam logic [DUTY_W-1:0] DUTY_FULL = 8'hff;
	localparam logic [STEP_W-1:0] STEP_RST = 16'h0000;
	localparam logic [PER_W-1:0] PER_RST = 7'h00;

	typedef enum logic [1:0] {
		TFP_SHUTDOWN,
		TFP_STARTUP,
		TFP_NORMAL,
		TFP_SLEEP
	} tfp_mode_t;

	// synchronised comparator results
	typedef struct packed {
		logic below_shutdown;
		logic above_restart;
		logic both_below_sleep;
		logic any_above_wake;
		logic above_overtemp;
		logic above_full_duty;
	} tfp_cmp_t;

	// fan drive and fault pins
	typedef struct packed {
		logic drive;
		logic drive_oe;
		logic fault_n;
		logic fault_oe;
	} tfp_pins_t;

endpackage

// File: verilog/tfp_time_base.sv
// time base: triangle counter plus one-cycle period pulse
// assumes a clock rate well above the triangle step rate
`timescale 1ns/10ps

module tfp_time_base
	import tfp_pkg::*;
#(
	parameter int unsigned STEP_DIV = STEP_CYCLES
)
(
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic run_i,
	output logic [DUTY_W-1:0] tri_o,
	output logic period_o
);

	typedef struct packed {
		logic [STEP_W-1:0] step;
		logic [DUTY_W-1:0] tri_val;
		logic down;
		logic period;
	} tfp_tb_state_t;

	tfp_tb_state_t state_ff;
	tfp_tb_state_t nxt_state;

	////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		nxt_state = state_ff;
		nxt_state.period = 1'b0;
		if (!run_i)
		begin
			// halted time base restarts at the bottom of the triangle
			nxt_state.step = STEP_RST;
			nxt_state.tri_val = DUTY_ZERO;
			nxt_state.down = 1'b0;
		end
		else if (state_ff.step == STEP_W'(STEP_DIV - 1))
		begin
			nxt_state.step = STEP_RST;
			if (!state_ff.down)
			begin
				nxt_state.tri_val = state_ff.tri_val + 8'h01;
				if (state_ff.tri_val == DUTY_MAX - 1)
					nxt_state.down = 1'b1;
			end
			else
			begin
				nxt_state.tri_val = state_ff.tri_val - 8'h01;
				if (state_ff.tri_val == 8'h01)
				begin
					nxt_state.down = 1'b0;
					nxt_state.period = 1'b1;
				end
			end
		end
		else
			nxt_state.step = state_ff.step + 16'h0001;
	end

	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
			state_ff <= '0;
		else
			state_ff <= nxt_state;
	end

	assign tri_o = state_ff.tri_val;
	assign period_o = state_ff.period;

endmodule

// File: verilog/tfp_fan_ctrl.sv
// thermal fan pwm controller: mode machine, duty select, pwm and fault output
// assumes comparator levels and duty codes come from analog front end, unsynchronised
`timescale 1ns/10ps

//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - pwm and startup period count run from one slow time base, 30 to 60 Hz; mode machine runs on the clock
// - in normal mode the higher of the two duty codes sets the duty
// - duty code maps linearly 0 to full; above full duty drive stays on
// - reset input brings the whole block to its power-on state
// - primary below shutdown level kills drive and fault at once, asynchronously
// - primary rising above restart level resets as at power-up, then starts up once a level exceeds the wake threshold
// - any start from off forces drive high for 64 time base periods
// - after power-up drive low, fault inactive; stay shut down while primary low
// - active-low fault asserted when primary exceeds overtemperature threshold
// - overtemperature leaves pwm untouched; drive keeps its pwm duty
// - fault released once primary drops under overtemperature threshold
// - normal mode enters sleep when both levels fall under sleep threshold
// - sleep releases drive and fault, and halts the time base
// - sleep is left only when a level exceeds the wake threshold or primary drops below shutdown level
// - waking behaves like power-on, startup interval included
// - after reset or power-up fan starts only above the wake threshold
// - shutdown acts regardless of secondary control level
module tfp_fan_ctrl
	import tfp_pkg::*;
#(
	parameter int unsigned STEP_DIV = STEP_CYCLES,
	parameter int unsigned START_PERIODS = STARTUP_PERIODS
)
(
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic below_shutdown_i,
	input wire logic above_restart_i,
	input wire logic both_below_sleep_i,
	input wire logic any_above_wake_i,
	input wire logic above_overtemp_i,
	input wire logic above_full_duty_i,
	input wire logic [DUTY_W-1:0] primary_control_level_i,
	input wire logic [DUTY_W-1:0] secondary_control_level_i,
	output logic fan_drive_o,
	output logic fan_drive_oe_o,
	output logic overtemp_fault_n_o,
	output logic overtemp_fault_oe_o,
	output logic [1:0] mode_o
);

	//////////////////////////////////////////////////////////////////////////
	// input synchronisers

	localparam int unsigned CMP_W = $bits(tfp_cmp_t);

	logic [CMP_W-1:0] cmp_raw;
	logic [CMP_W-1:0] cmp_meta_ff;
	logic [CMP_W-1:0] cmp_sync_ff;
	logic [DUTY_W-1:0] pri_meta_ff;
	logic [DUTY_W-1:0] pri_sync_ff;
	logic [DUTY_W-1:0] sec_meta_ff;
	logic [DUTY_W-1:0] sec_sync_ff;
	tfp_cmp_t cmp;

	assign cmp_raw = {below_shutdown_i, above_restart_i, both_below_sleep_i,
		any_above_wake_i, above_overtemp_i, above_full_duty_i};

	// duty codes are slow analog levels; a torn code lasts one cycle only
	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			cmp_meta_ff <= '0;
			cmp_sync_ff <= '0;
			pri_meta_ff <= DUTY_ZERO;
			pri_sync_ff <= DUTY_ZERO;
			sec_meta_ff <= DUTY_ZERO;
			sec_sync_ff <= DUTY_ZERO;
		end
		else
		begin
			cmp_meta_ff <= cmp_raw;
			cmp_sync_ff <= cmp_meta_ff;
			pri_meta_ff <= primary_control_level_i;
			pri_sync_ff <= pri_meta_ff;
			sec_meta_ff <= secondary_control_level_i;
			sec_sync_ff <= sec_meta_ff;
		end
	end

	assign cmp = tfp_cmp_t'(cmp_sync_ff);

	//////////////////////////////////////////////////////////////////////////
	// time base

	logic tb_run;
	logic [DUTY_W-1:0] tri_val;
	logic period_pulse;

	tfp_time_base #(
		.STEP_DIV(STEP_DIV)
	) u_time_base (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.run_i(tb_run),
		.tri_o(tri_val),
		.period_o(period_pulse)
	);

	//////////////////////////////////////////////////////////////////////////
	// mode machine

	typedef struct packed {
		tfp_mode_t mode;
		logic [PER_W-1:0] periods;
		logic armed;
		tfp_pins_t pins;
	} tfp_state_t;

	tfp_state_t state_ff;
	tfp_state_t nxt_state;
	// pins sit in flops of their own: only they take the raw shutdown reset
	tfp_mode_t mode_ff;
	logic [PER_W-1:0] periods_ff;
	logic armed_ff;
	tfp_pins_t pins_ff;
	logic [DUTY_W-1:0] duty;

	assign state_ff = '{mode: mode_ff, periods: periods_ff, armed: armed_ff, pins: pins_ff};
	logic pwm_on;

	// time base stops in shutdown and sleep
	assign tb_run = (state_ff.mode == TFP_STARTUP) || (state_ff.mode == TFP_NORMAL);

	always_comb
	begin
		// higher of the two codes controls
		if (pri_sync_ff >= sec_sync_ff)
			duty = pri_sync_ff;
		else
			duty = sec_sync_ff;
		pwm_on = (duty > tri_val) || (duty == DUTY_FULL);
	end

	always_comb
	begin
		nxt_state = state_ff;
		unique case (state_ff.mode)
			TFP_SHUTDOWN:
			begin
				// armed once primary rises above the restart level
				nxt_state.pins.drive = 1'b0;
				nxt_state.pins.drive_oe = 1'b0;
				nxt_state.pins.fault_n = 1'b1;
				nxt_state.pins.fault_oe = 1'b0;
				nxt_state.periods = PER_RST;
				if (cmp.above_restart)
					nxt_state.armed = 1'b1;
				if (state_ff.armed && cmp.any_above_wake)
				begin
					nxt_state.mode = TFP_STARTUP;
					nxt_state.armed = 1'b0;
					nxt_state.pins.drive = 1'b1;
					nxt_state.pins.drive_oe = 1'b1;
				end
			end
			TFP_STARTUP:
			begin
				nxt_state.pins.drive = 1'b1;
				nxt_state.pins.drive_oe = 1'b1;
				nxt_state.pins.fault_n = !cmp.above_overtemp;
				nxt_state.pins.fault_oe = cmp.above_overtemp;
				if (period_pulse)
				begin
					if (state_ff.periods == PER_W'(START_PERIODS - 1))
						nxt_state.mode = TFP_NORMAL;
					else
						nxt_state.periods = state_ff.periods + 7'h01;
				end
			end
			TFP_NORMAL:
			begin
				// full duty comparator backs the code against offset errors
				nxt_state.pins.drive = pwm_on || cmp.above_full_duty;
				nxt_state.pins.drive_oe = 1'b1;
				nxt_state.pins.fault_n = !cmp.above_overtemp;
				nxt_state.pins.fault_oe = cmp.above_overtemp;
				if (cmp.both_below_sleep)
				begin
					nxt_state.mode = TFP_SLEEP;
					nxt_state.pins.drive = 1'b0;
					nxt_state.pins.drive_oe = 1'b0;
					nxt_state.pins.fault_n = 1'b1;
					nxt_state.pins.fault_oe = 1'b0;
				end
			end
			TFP_SLEEP:
			begin
				nxt_state.pins.drive = 1'b0;
				nxt_state.pins.drive_oe = 1'b0;
				nxt_state.pins.fault_n = 1'b1;
				nxt_state.pins.fault_oe = 1'b0;
				nxt_state.periods = PER_RST;
				if (cmp.any_above_wake)
				begin
					nxt_state.mode = TFP_STARTUP;
					nxt_state.pins.drive = 1'b1;
					nxt_state.pins.drive_oe = 1'b1;
				end
			end
		endcase
		// shutdown wins over every mode, whatever the secondary level
		if (cmp.below_shutdown)
		begin
			nxt_state.mode = TFP_SHUTDOWN;
			nxt_state.periods = PER_RST;
			nxt_state.armed = 1'b0;
			nxt_state.pins = '{drive: 1'b0, drive_oe: 1'b0, fault_n: 1'b1, fault_oe: 1'b0};
		end
	end

	// shutdown also clears pins straight from the raw comparator, no clock
	logic kill;
	assign kill = rst_i || below_shutdown_i;

	// mode and counters take the synchronised path; pins take the raw one
	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			mode_ff <= TFP_SHUTDOWN;
			periods_ff <= PER_RST;
			armed_ff <= 1'b1;
		end
		else
		begin
			mode_ff <= nxt_state.mode;
			periods_ff <= nxt_state.periods;
			armed_ff <= nxt_state.armed;
		end
	end

	always_ff @(posedge ref_clk_i or posedge kill)
	begin
		if (kill)
			pins_ff <= '{drive: 1'b0, drive_oe: 1'b0, fault_n: 1'b1, fault_oe: 1'b0};
		else
			pins_ff <= nxt_state.pins;
	end

	assign fan_drive_o = pins_ff.drive;
	assign fan_drive_oe_o = pins_ff.drive_oe;
	assign overtemp_fault_n_o = pins_ff.fault_n;
	assign overtemp_fault_oe_o = pins_ff.fault_oe;
	assign mode_o = mode_ff;

endmodule

// File: verification/tfp_sensor_model.sv
// front end model: levels in percent of supply to comparator bits and duty codes
// assumes the bench changes levels away from the rising clock edge
`timescale 1ns/10ps

module tfp_sensor_model
	import tfp_pkg::*;
(
	input wire logic [6:0] pct1_i,
	input wire logic [6:0] pct2_i,
	input wire logic [6:0] sleep_pct_i,
	output tfp_cmp_t cmp_o,
	output logic [DUTY_W-1:0] duty1_o,
	output logic [DUTY_W-1:0] duty2_o
);
	function automatic logic [DUTY_W-1:0] code(input logic [6:0] p);
		int v;
		v = (int'(p) - 30) * 255 / 40;
		return v < 0 ? 8'h00 : v > 255 ? 8'hff : v[7:0];
	endfunction

	// sleep level 0 never trips, as a grounded threshold pin
	always_comb
	begin
		cmp_o.below_shutdown = pct1_i < 7'h05;
		cmp_o.above_restart = pct1_i > 7'h08;
		cmp_o.both_below_sleep = pct1_i < sleep_pct_i && pct2_i < sleep_pct_i;
		cmp_o.any_above_wake = pct1_i > sleep_pct_i + 7'h0b || pct2_i > sleep_pct_i + 7'h0b;
		cmp_o.above_overtemp = pct1_i > 7'h4d;
		cmp_o.above_full_duty = pct1_i > 7'h46;
		duty1_o = code(pct1_i);
		duty2_o = code(pct2_i);
	end
endmodule

// File: verification/tfp_fan_ctrl_sva.sv
// port assertions of the fan controller
// assumes one clock and the asynchronous high reset of the block
`timescale 1ns/10ps

module tfp_fan_ctrl_sva
	import tfp_pkg::*;
#(
	parameter int unsigned STEP_DIV = STEP_CYCLES,
	parameter int unsigned START_PERIODS = STARTUP_PERIODS
)
(
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic below_shutdown_i,
	input wire logic above_restart_i,
	input wire logic both_below_sleep_i,
	input wire logic any_above_wake_i,
	input wire logic above_overtemp_i,
	input wire logic above_full_duty_i,
	input wire logic [DUTY_W-1:0] primary_control_level_i,
	input wire logic [DUTY_W-1:0] secondary_control_level_i,
	input wire logic fan_drive_o,
	input wire logic fan_drive_oe_o,
	input wire logic overtemp_fault_n_o,
	input wire logic overtemp_fault_oe_o,
	input wire logic [1:0] mode_o
);
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (rst_i);

	a_shut_pins: assert property (
		below_shutdown_i |-> !fan_drive_oe_o && overtemp_fault_n_o)
		else $error("pins active in shutdown");
	a_start_high: assert property (mode_o == 2'h1 && !below_shutdown_i |-> fan_drive_o)
		else $error("drive low in startup");
	a_sleep_drop: assert property (
		mode_o == 2'h3 |-> !fan_drive_oe_o && !overtemp_fault_oe_o)
		else $error("sleep drives pins");
	a_fault_set: assert property (
		(mode_o == 2'h2 && above_overtemp_i)[*4] |-> !overtemp_fault_n_o)
		else $error("fault missing");
	a_fault_clear: assert property ((!above_overtemp_i)[*4] |-> overtemp_fault_n_o)
		else $error("fault stuck");
	a_full_on: assert property ((mode_o == 2'h2 && above_full_duty_i)[*4] |-> fan_drive_o)
		else $error("drive not full");
	a_sleep_entry: assert property (
		$rose(both_below_sleep_i) && mode_o == 2'h2 && !below_shutdown_i |-> ##[1:4] mode_o == 2'h3)
		else $error("no sleep");
	a_sleep_hold: assert property (
		(mode_o == 2'h3 && !any_above_wake_i && !below_shutdown_i)[*4] |=> mode_o == 2'h3)
		else $error("woke early");
	a_wake_start: assert property (mode_o == 2'h3 ##1 mode_o != 2'h3 |-> mode_o != 2'h2)
		else $error("wake skipped startup");
endmodule

bind tfp_fan_ctrl tfp_fan_ctrl_sva #(.STEP_DIV(STEP_DIV), .START_PERIODS(START_PERIODS))
	i_tfp_fan_ctrl_sva (.ref_clk_i, .rst_i, .below_shutdown_i, .above_restart_i,
	.both_below_sleep_i, .any_above_wake_i, .above_overtemp_i, .above_full_duty_i,
	.primary_control_level_i, .secondary_control_level_i, .fan_drive_o, .fan_drive_oe_o,
	.overtemp_fault_n_o, .overtemp_fault_oe_o, .mode_o);

// File: verification/tfp_fan_ctrl_tb.sv
// self-checking bench of the fan controller driven through the front end model
// assumes shortened time base and startup counts
`timescale 1ns/10ps

module tfp_fan_ctrl_tb
	import tfp_pkg::*;
;
	localparam int SD = 2;
	localparam int SP = 4;
	localparam int PER = 510 * SD;
	logic ref_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [6:0] p1 = 7'h1e, p2 = 7'h1e, slp = 7'h19;
	tfp_cmp_t cmp;
	logic [DUTY_W-1:0] d1, d2;
	logic drv, drv_oe, flt_n, flt_oe;
	logic [1:0] mode;
	int n_errors = 0;
	int comparisons = 0;

	initial forever #4 ref_clk_i = ~ref_clk_i;
	tfp_sensor_model i_tfp_sensor_model (.pct1_i(p1), .pct2_i(p2), .sleep_pct_i(slp),
		.cmp_o(cmp), .duty1_o(d1), .duty2_o(d2));
	tfp_fan_ctrl #(.STEP_DIV(SD), .START_PERIODS(SP)) i_tfp_fan_ctrl (.ref_clk_i(ref_clk_i),
		.rst_i(rst_i), .below_shutdown_i(cmp.below_shutdown), .above_restart_i(cmp.above_restart),
		.both_below_sleep_i(cmp.both_below_sleep), .any_above_wake_i(cmp.any_above_wake),
		.above_overtemp_i(cmp.above_overtemp), .above_full_duty_i(cmp.above_full_duty),
		.primary_control_level_i(d1), .secondary_control_level_i(d2), .fan_drive_o(drv),
		.fan_drive_oe_o(drv_oe), .overtemp_fault_n_o(flt_n), .overtemp_fault_oe_o(flt_oe),
		.mode_o(mode));

	////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			n_errors++;
			$display("unexpected at %0t: got %0h want %0h", $time, got, exp);
		end
	endtask

	task automatic lv(input logic [6:0] a, input logic [6:0] b);
		@(negedge ref_clk_i);
		p1 = a;
		p2 = b;
	endtask

	task automatic waitm(input logic [1:0] m, input int lim);
		for (int i = 0; i < lim && mode !== m; i++)
			@(negedge ref_clk_i);
		chk(mode, m);
	endtask

	// high cycles over one period; tolerance covers sync delay
	task automatic duty(input int lo, input int hi);
		int n;
		n = 0;
		repeat (PER)
		begin
			@(negedge ref_clk_i);
			n += (drv === 1'b1);
		end
		chk(n >= lo && n <= hi, 1'b1);
	endtask

	task automatic t_start(input logic [6:0] a, input logic [6:0] b);
		int n;
		lv(a, b);
		waitm(2'h1, 6);
		chk({drv, drv_oe}, 2'h3);
		n = 0;
		while (mode === 2'h1 && n < SP * PER + 50)
		begin
			@(negedge ref_clk_i);
			n++;
		end
		chk(n >= SP * PER - 4 && n <= SP * PER + 4, 1'b1);
		chk(mode, 2'h2);
	endtask

	task automatic t_run;
		lv(7'h28, 7'h32);
		duty(480, 540);
		lv(7'h3c, 7'h28);
		duty(736, 792);
		lv(7'h50, 7'h1e);
		repeat (6) @(negedge ref_clk_i);
		chk({flt_n, flt_oe}, 2'h1);
		duty(PER, PER);
		lv(7'h32, 7'h1e);
		repeat (6) @(negedge ref_clk_i);
		chk({flt_n, flt_oe}, 2'h2);
	endtask

	task automatic t_sleep;
		lv(7'h14, 7'h14);
		waitm(2'h3, 6);
		chk({drv_oe, flt_oe, flt_n}, 3'h1);
		lv(7'h22, 7'h14);
		repeat (20) @(negedge ref_clk_i);
		chk(mode, 2'h3);
		t_start(7'h28, 7'h14);
	endtask

	task automatic t_shut;
		lv(7'h50, 7'h1e);
		repeat (6) @(negedge ref_clk_i);
		lv(7'h00, 7'h3c);
		#1;
		chk({drv, drv_oe, flt_n, flt_oe}, 4'h2);
		waitm(2'h0, 5);
		lv(7'h1e, 7'h14);
		repeat (20) @(negedge ref_clk_i);
		chk(mode, 2'h0);
		t_start(7'h1e, 7'h3c);
		chk(flt_n, 1'b1);
		slp = 7'h00;
		lv(7'h0a, 7'h0a);
		repeat (20) @(negedge ref_clk_i);
		chk(mode, 2'h2);
	endtask

	task automatic results;
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////
	initial
	begin
		repeat (12) @(negedge ref_clk_i);
		chk({mode, drv, drv_oe, flt_n, flt_oe}, 6'h02);
		rst_i = 1'b0;
		repeat (20) @(negedge ref_clk_i);
		chk(mode, 2'h0);
		t_start(7'h32, 7'h1e);
		t_run;
		t_sleep;
		t_shut;
		results;
	end

	initial
	begin
		#400000;
		n_errors++;
		results;
	end
endmodule
